/* hw/ssrm_pkg.sv */
package ssrm_pkg;

    // frame geometry
    localparam int          FRAME_BITS   = 16;
    localparam int          OUT_COUNT    = 4;
    localparam int          SYNC_STAGES  = 2;

    // incoming word layout
    localparam int          IN_WD_BIT    = 15;
    localparam int          IN_ADDR_HI   = 12;
    localparam int          IN_ADDR_LO   = 8;
    localparam int          IN_SEL_HI    = 4;
    localparam logic [4:0]  ADDR_STATUS  = 5'h00;

    // response word layout
    localparam int          RSP_WD_BIT   = 15;
    localparam int          RSP_UV_BIT   = 14;
    localparam int          RSP_OV_BIT   = 13;

    // view decode: low three bits of the select code
    localparam logic [2:0]  VIEW_FAULT   = 3'h0;
    localparam logic [2:0]  VIEW_GLOBAL1 = 3'h1;
    localparam logic [2:0]  VIEW_LEVEL   = 3'h2;
    localparam logic [2:0]  VIEW_TIMING  = 3'h3;
    localparam logic [2:0]  VIEW_DIRECT  = 3'h4;
    localparam logic [2:0]  VIEW_GLOBAL5 = 3'h5;
    localparam logic [2:0]  VIEW_GLOBAL6 = 3'h6;
    localparam logic [2:0]  VIEW_GLOBAL7 = 3'h7;

    // full select codes of the global views
    localparam logic [4:0]  SEL_ONOFF    = 5'h01;
    localparam logic [4:0]  SEL_SENSE    = 5'h09;
    localparam logic [4:0]  SEL_SUPPLY   = 5'h05;
    localparam logic [4:0]  SEL_WDOG     = 5'h0d;
    localparam logic [4:0]  SEL_FSPIN    = 5'h06;
    localparam logic [4:0]  SEL_DPIN     = 5'h0e;
    localparam logic [4:0]  SEL_OTUPPER  = 5'h0f;

    // values after reset
    localparam logic [4:0]  RST_SELECT   = 5'h00;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [3:0]  RST_NIBBLE   = 4'h0;
    localparam logic [3:0]  RST_COUNT    = 4'h0;

    typedef enum logic {
        LINK_IDLE,
        LINK_FRAME
    } ssrm_link_type;

endpackage

/* hw/ssrm_sync.sv */
`timescale 1ns/1ns
module ssrm_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock, reset, enable
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_ce,
    // data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    import ssrm_pkg::*;

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        if (i_ce) begin
            meta_next = i_async;
            sync_next = meta_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;

endmodule

/* hw/ssrm_top.sv */
// Function
// - response: watchdog, supplies, select echo, summary
// - selected view persists until next select
// - only multiple-of-16 frames take effect
// - select code top bits pick output
// - fault view returns four live flags
// - fault pin; latched faults cleared by switch-off
// - code 00001 returns serial on/off bits
// - code 01001 returns sense enable bits
// - level view returns trip level bits
// - timing view returns blanking/disable bits
// - direct view returns direct input config
// - code 00101 returns supply protect config
// - code 01101 returns watchdog field, flag
// - timeout flag only when expired and failsafe
// - code 00110 returns failsafe states
// - failsafe states come from strap pin
// - same view: watchdog enabled, wake level
// - code 01110 returns direct pin levels
// - code 01111 returns upper latch disables
`timescale 1ns/1ns
module ssrm_top (
    // clock, reset, enable
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_CE,
    // serial link pins
    input  wire logic        I_SCLK,
    input  wire logic        I_CS_N,
    input  wire logic        I_SI,
    output logic             O_SO,
    output logic             O_SO_OE,
    // device pins
    input  wire logic        I_WAKE,
    input  wire logic [3:0]  I_DIRECT_PIN,
    input  wire logic [1:0]  I_FAILSAFE_STRAP,
    output logic             O_FAULT_FLAG_PIN_N,
    // programmed configuration
    input  wire logic [3:0]  I_SERIAL_ONOFF_BITS,
    input  wire logic [3:0]  I_SENSE_ENABLE_BITS,
    input  wire logic [15:0] I_CURRENT_LEVEL_CONFIG,
    input  wire logic [15:0] I_BLANKING_OPENLOAD_CONFIG,
    input  wire logic [15:0] I_DIRECT_INPUT_CONFIG,
    input  wire logic [3:0]  I_SUPPLY_PROTECT_CONFIG,
    input  wire logic [1:0]  I_WATCHDOG_PERIOD_SEL,
    input  wire logic [1:0]  I_OVERTEMP_LATCH_UPPER,
    // live status
    input  wire logic        I_WATCHDOG_ENABLED_IND,
    input  wire logic        I_WATCHDOG_EXPIRED,
    input  wire logic        I_FAILSAFE_MODE,
    input  wire logic [3:0]  I_OVERTEMP_FLAG,
    input  wire logic [3:0]  I_OVERCURRENT_HIGH_FLAG,
    input  wire logic [3:0]  I_OVERCURRENT_LOW_FLAG,
    input  wire logic [3:0]  I_OPEN_LOAD_FLAG,
    input  wire logic        I_UNDERVOLTAGE_FLAG,
    input  wire logic        I_OVERVOLTAGE_FLAG,
    // decoded frame results
    output logic [4:0]       O_READBACK_SELECT_CODE,
    output logic             O_WATCHDOG_ECHO
);
    import ssrm_pkg::*;

    // nibble of one output out of a packed per-output field
    function automatic logic [3:0] pick_out(input logic [15:0] flat,
                                            input logic [1:0]  idx);
        pick_out = flat[idx*4 +: 4];
    endfunction

    // pin synchronisers
    localparam int          SYNC_W   = 10;
    localparam logic [9:0]  SYNC_RST = 10'h002;

    logic [9:0] pins_sync;
    logic       sclk_s;
    logic       csn_s;
    logic       si_s;
    logic       wake_s;
    logic [3:0] dpin_s;
    logic [1:0] strap_s;

    ssrm_sync #(
        .WIDTH     (SYNC_W),
        .RESET_VAL (SYNC_RST)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rstn  (I_RSTN),
        .i_ce    (I_CE),
        .i_async ({I_FAILSAFE_STRAP, I_DIRECT_PIN, I_WAKE, I_SI,
                   I_CS_N, I_SCLK}),
        .o_sync  (pins_sync)
    );

    assign sclk_s  = pins_sync[0];
    assign csn_s   = pins_sync[1];
    assign si_s    = pins_sync[2];
    assign wake_s  = pins_sync[3];
    assign dpin_s  = pins_sync[7:4];
    assign strap_s = pins_sync[9:8];

    // response word assembly
    logic [4:0]  sel_reg;
    logic        wd_echo_reg;
    logic [3:0]  latched_reg;
    logic [3:0]  fault_summary;
    logic [3:0]  view_nibble;
    logic [15:0] rsp_word;
    logic [1:0]  out_idx;
    logic [3:0]  ot_latch_dis;
    logic        wd_expired_flag;
    logic        failsafe_state_out2;
    logic        failsafe_state_out0;

    assign out_idx = sel_reg[4:3];
    // latching of overtemperature is off where the disable bit is 1
    assign ot_latch_dis = {I_OVERTEMP_LATCH_UPPER,
                           I_SUPPLY_PROTECT_CONFIG[3:2]};
    assign wd_expired_flag = I_WATCHDOG_EXPIRED & I_FAILSAFE_MODE;
    // strap code read straight as the two fail-safe states
    assign failsafe_state_out2 = strap_s[1];
    assign failsafe_state_out0 = strap_s[0];
    assign fault_summary = latched_reg | I_OVERTEMP_FLAG
                         | I_OVERCURRENT_HIGH_FLAG | I_OVERCURRENT_LOW_FLAG
                         | I_OPEN_LOAD_FLAG;

    always_comb begin
        view_nibble = RST_NIBBLE;
        case (sel_reg[2:0])
            VIEW_FAULT: begin
                view_nibble = {I_OVERTEMP_FLAG[out_idx],
                               I_OVERCURRENT_HIGH_FLAG[out_idx],
                               I_OVERCURRENT_LOW_FLAG[out_idx],
                               I_OPEN_LOAD_FLAG[out_idx]};
            end
            VIEW_GLOBAL1: begin
                if (sel_reg == SEL_ONOFF) begin
                    view_nibble = I_SERIAL_ONOFF_BITS;
                end else if (sel_reg == SEL_SENSE) begin
                    view_nibble = I_SENSE_ENABLE_BITS;
                end
            end
            VIEW_LEVEL: begin
                view_nibble = pick_out(I_CURRENT_LEVEL_CONFIG,
                                       out_idx);
            end
            VIEW_TIMING: begin
                view_nibble = pick_out(I_BLANKING_OPENLOAD_CONFIG,
                                       out_idx);
            end
            VIEW_DIRECT: begin
                view_nibble = pick_out(I_DIRECT_INPUT_CONFIG,
                                       out_idx);
            end
            VIEW_GLOBAL5: begin
                if (sel_reg == SEL_SUPPLY) begin
                    view_nibble = I_SUPPLY_PROTECT_CONFIG;
                end else if (sel_reg == SEL_WDOG) begin
                    view_nibble = {1'b0, wd_expired_flag,
                                   I_WATCHDOG_PERIOD_SEL};
                end
            end
            VIEW_GLOBAL6: begin
                if (sel_reg == SEL_FSPIN) begin
                    view_nibble = {failsafe_state_out2,
                                   failsafe_state_out0,
                                   I_WATCHDOG_ENABLED_IND,
                                   wake_s};
                end else if (sel_reg == SEL_DPIN) begin
                    view_nibble = dpin_s;
                end
            end
            VIEW_GLOBAL7: begin
                // don't-care low bits returned as zero
                if (sel_reg == SEL_OTUPPER) begin
                    view_nibble = {I_OVERTEMP_LATCH_UPPER, 2'b00};
                end
            end
            default: begin
                view_nibble = RST_NIBBLE;
            end
        endcase
    end

    assign rsp_word = {wd_echo_reg, I_UNDERVOLTAGE_FLAG,
                       I_OVERVOLTAGE_FLAG, sel_reg, fault_summary,
                       view_nibble};

    // serial link: one shift register serves status out and daisy chain
    ssrm_link_type link_reg;
    ssrm_link_type link_next;
    logic          sclk_q_reg;
    logic          csn_q_reg;
    logic [15:0]   shift_reg;
    logic [15:0]   shift_next;
    logic [3:0]    cnt_reg;
    logic [3:0]    cnt_next;
    logic          seen_reg;
    logic          seen_next;
    logic          so_reg;
    logic          so_next;
    logic          oe_reg;
    logic          oe_next;
    logic [4:0]    sel_next;
    logic          wd_echo_next;
    logic          cs_fall;
    logic          cs_rise;
    logic          sclk_rise;
    logic          sclk_fall;

    assign cs_fall   = csn_q_reg & ~csn_s;
    assign cs_rise   = ~csn_q_reg & csn_s;
    assign sclk_rise = ~sclk_q_reg & sclk_s;
    assign sclk_fall = sclk_q_reg & ~sclk_s;

    always_comb begin
        link_next    = link_reg;
        shift_next   = shift_reg;
        cnt_next     = cnt_reg;
        seen_next    = seen_reg;
        so_next      = so_reg;
        oe_next      = oe_reg;
        sel_next     = sel_reg;
        wd_echo_next = wd_echo_reg;
        case (link_reg)
            LINK_IDLE: begin
                if (cs_fall) begin
                    // word is frozen at select so it cannot tear
                    shift_next = rsp_word;
                    so_next    = rsp_word[FRAME_BITS-1];
                    oe_next    = 1'b1;
                    cnt_next   = RST_COUNT;
                    seen_next  = 1'b0;
                    link_next  = LINK_FRAME;
                end
            end
            LINK_FRAME: begin
                if (cs_rise) begin
                    oe_next   = 1'b0;
                    link_next = LINK_IDLE;
                    if (seen_reg && cnt_reg == RST_COUNT) begin
                        wd_echo_next = shift_reg[IN_WD_BIT];
                        if (shift_reg[IN_ADDR_HI:IN_ADDR_LO]
                                == ADDR_STATUS) begin
                            sel_next = shift_reg[IN_SEL_HI:0];
                        end
                    end
                end else if (sclk_rise) begin
                    shift_next = {shift_reg[FRAME_BITS-2:0], si_s};
                    cnt_next   = cnt_reg + 4'h1;
                    seen_next  = 1'b1;
                end else if (sclk_fall) begin
                    so_next = shift_reg[FRAME_BITS-1];
                end
            end
            default: begin
                link_next = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            link_reg    <= LINK_IDLE;
            sclk_q_reg  <= 1'b0;
            csn_q_reg   <= 1'b1;
            shift_reg   <= RST_WORD;
            cnt_reg     <= RST_COUNT;
            seen_reg    <= 1'b0;
            so_reg      <= 1'b0;
            oe_reg      <= 1'b0;
            sel_reg     <= RST_SELECT;
            wd_echo_reg <= 1'b0;
        end else if (I_CE) begin
            link_reg    <= link_next;
            sclk_q_reg  <= sclk_s;
            csn_q_reg   <= csn_s;
            shift_reg   <= shift_next;
            cnt_reg     <= cnt_next;
            seen_reg    <= seen_next;
            so_reg      <= so_next;
            oe_reg      <= oe_next;
            sel_reg     <= sel_next;
            wd_echo_reg <= wd_echo_next;
        end
    end

    // fault pin and latched faults
    logic [3:0] latched_next;
    logic [3:0] onoff_q_reg;
    logic [3:0] dpin_q_reg;
    logic [3:0] switch_off;
    logic [3:0] latch_set;
    logic       fault_n_reg;
    logic       fault_n_next;

    // a falling command bit or direct pin is a switch-off request
    assign switch_off = (onoff_q_reg & ~I_SERIAL_ONOFF_BITS)
                      | (dpin_q_reg & ~dpin_s);
    assign latch_set  = I_OVERCURRENT_HIGH_FLAG | I_OVERCURRENT_LOW_FLAG
                      | (I_OVERTEMP_FLAG & ~ot_latch_dis);

    always_comb begin
        // set beats a clear in the same cycle
        latched_next = (latched_reg & ~switch_off) | latch_set;
        fault_n_next = ~(|fault_summary | I_UNDERVOLTAGE_FLAG
                         | I_OVERVOLTAGE_FLAG);
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            latched_reg <= RST_NIBBLE;
            onoff_q_reg <= RST_NIBBLE;
            dpin_q_reg  <= RST_NIBBLE;
            fault_n_reg <= 1'b1;
        end else if (I_CE) begin
            latched_reg <= latched_next;
            onoff_q_reg <= I_SERIAL_ONOFF_BITS;
            dpin_q_reg  <= dpin_s;
            fault_n_reg <= fault_n_next;
        end
    end

    assign O_SO                   = so_reg;
    assign O_SO_OE                = oe_reg;
    assign O_FAULT_FLAG_PIN_N     = fault_n_reg;
    assign O_READBACK_SELECT_CODE = sel_reg;
    assign O_WATCHDOG_ECHO        = wd_echo_reg;

endmodule

/* dv/ssrm_top_chk.sv */
`timescale 1ns/1ns
module ssrm_top_chk (
    // clock, reset, link
    input  wire logic       I_CLK,
    input  wire logic       I_RSTN,
    input  wire logic       I_CE,
    input  wire logic       I_SCLK,
    input  wire logic       I_CS_N,
    input  wire logic       O_SO,
    input  wire logic       O_SO_OE,
    // faults
    input  wire logic [3:0] I_OVERTEMP_FLAG,
    input  wire logic [3:0] I_OVERCURRENT_HIGH_FLAG,
    input  wire logic [3:0] I_OVERCURRENT_LOW_FLAG,
    input  wire logic [3:0] I_OPEN_LOAD_FLAG,
    input  wire logic       I_UNDERVOLTAGE_FLAG,
    input  wire logic       I_OVERVOLTAGE_FLAG,
    input  wire logic       O_FAULT_FLAG_PIN_N,
    // frame results
    input  wire logic [4:0] O_READBACK_SELECT_CODE,
    input  wire logic       O_WATCHDOG_ECHO
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    logic any_flt;
    assign any_flt = |{I_OVERTEMP_FLAG, I_OVERCURRENT_HIGH_FLAG,
                       I_OVERCURRENT_LOW_FLAG, I_OPEN_LOAD_FLAG,
                       I_UNDERVOLTAGE_FLAG, I_OVERVOLTAGE_FLAG};

    sequence frame_open;
        $fell(I_CS_N);
    endsequence
    // five idle cycles cover the two-stage sync path and the output register
    sequence frame_close;
        $rose(I_CS_N) ##1 I_CS_N [*5];
    endsequence

    AST_RST_STATE: assert property (
        $rose(I_RSTN) |-> O_READBACK_SELECT_CODE == 5'h00
        && !O_WATCHDOG_ECHO && !O_SO_OE)
        else $error("state not cleared by reset");
    AST_FLT_SET: assert property (
        I_CE && any_flt |=> !O_FAULT_FLAG_PIN_N)
        else $error("fault pin not driven on fault");
    AST_FLT_REL: assert property (
        $rose(O_FAULT_FLAG_PIN_N) |-> !$past(any_flt))
        else $error("fault pin released during live fault");
    AST_SEL_HOLD: assert property (
        $changed(O_READBACK_SELECT_CODE) |-> I_CS_N && $past(I_CS_N, 2))
        else $error("select changed inside a frame");
    AST_ECHO_HOLD: assert property (
        $changed(O_WATCHDOG_ECHO) |-> I_CS_N && $past(I_CS_N, 2))
        else $error("echo changed inside a frame");
    AST_OE_ON: assert property (
        frame_open |-> ##[1:4] O_SO_OE)
        else $error("serial output not enabled after select");
    AST_OE_OFF: assert property (
        frame_close |-> !O_SO_OE)
        else $error("serial output still enabled after frame");
    AST_SO_SHIFT: assert property (
        $changed(O_SO) && O_SO_OE && $past(O_SO_OE) |-> !$past(I_SCLK))
        else $error("serial output moved while clock high");
endmodule

bind ssrm_top ssrm_top_chk u_chk (.*);

/* dv/ssrm_master.sv */
`timescale 1ns/1ns
module ssrm_master (
    // reference for launch phase
    input  wire logic i_clk,
    // link
    input  wire logic i_so,
    input  wire logic i_so_oe,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si
);
    // serial clock stands low outside frames
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b0;
    end

    // 80 ns half period; so sampled just before each rising edge
    task automatic xfer(input logic [31:0] tx, input int nb,
                        output logic [15:0] rx);
        logic [15:0] r;
        r = 16'h0000;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        #80;
        for (int k = nb - 1; k >= 0; k--) begin
            o_si = tx[k];
            #80;
            r = {r[14:0], i_so_oe ? i_so : 1'bx};
            o_sclk = 1'b1;
            #80;
            o_sclk = 1'b0;
        end
        #80;
        o_cs_n = 1'b1;
        // no pull on si once released: show the opposite level
        o_si = ~o_si;
        #160;
        rx = r;
    endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import ssrm_pkg::*;
    logic        clk     = 1'b0;
    logic        rstn    = 1'b0;
    logic        sclk, cs_n, si, so, so_oe, pin_n, echo;
    logic        wake    = 1'b1;
    logic        watchdog_enabled_ind   = 1'b1;
    logic        wd_exp  = 1'b1;
    logic        fs_mode = 1'b1;
    logic        uv      = 1'b0;
    logic        ov      = 1'b0;
    logic        wd_tgl  = 1'b0;
    logic [1:0]  strap   = 2'b10;
    logic [1:0]  wdper   = 2'b10;
    logic [1:0]  otup    = 2'b01;
    logic [3:0]  dpin    = 4'h9;
    logic [3:0]  onoff   = 4'ha;
    logic [3:0]  sense   = 4'h5;
    logic [3:0]  supply  = 4'h6;
    logic [3:0]  otf     = 4'h0;
    logic [3:0]  ochf    = 4'h0;
    logic [3:0]  oclf    = 4'h0;
    logic [3:0]  olf     = 4'h0;
    logic [4:0]  sel;
    logic [15:0] lvl     = 16'hc3a5;
    logic [15:0] blank   = 16'h1e2d;
    logic [15:0] dcfg    = 16'h96f0;
    logic [15:0] rx;
    int          err_total = 0;
    int          n_checks  = 0;
    // select code beside the view nibble it must return
    logic [4:0]  tsel [17] = '{5'h01, 5'h09, 5'h05, 5'h0d, 5'h06, 5'h0e,
        5'h0f, 5'h02, 5'h0a, 5'h12, 5'h1a, 5'h03, 5'h1b, 5'h0c, 5'h14,
        5'h00, 5'h07};
    logic [3:0]  tnib [17] = '{4'ha, 4'h5, 4'h6, 4'h6, 4'hb, 4'h9, 4'h4,
        4'h5, 4'ha, 4'h3, 4'hc, 4'hd, 4'h1, 4'hf, 4'h6, 4'h0, 4'h0};

    always #5 clk = ~clk;

    ssrm_top u_dut (
        .I_CLK(clk), .I_RSTN(rstn), .I_CE(1'b1), .I_SCLK(sclk),
        .I_CS_N(cs_n), .I_SI(si), .O_SO(so), .O_SO_OE(so_oe),
        .I_WAKE(wake), .I_DIRECT_PIN(dpin), .I_FAILSAFE_STRAP(strap),
        .O_FAULT_FLAG_PIN_N(pin_n), .I_SERIAL_ONOFF_BITS(onoff),
        .I_SENSE_ENABLE_BITS(sense), .I_CURRENT_LEVEL_CONFIG(lvl),
        .I_BLANKING_OPENLOAD_CONFIG(blank),
        .I_DIRECT_INPUT_CONFIG(dcfg), .I_SUPPLY_PROTECT_CONFIG(supply),
        .I_WATCHDOG_PERIOD_SEL(wdper), .I_OVERTEMP_LATCH_UPPER(otup),
        .I_WATCHDOG_ENABLED_IND(watchdog_enabled_ind), .I_WATCHDOG_EXPIRED(wd_exp),
        .I_FAILSAFE_MODE(fs_mode), .I_OVERTEMP_FLAG(otf),
        .I_OVERCURRENT_HIGH_FLAG(ochf), .I_OVERCURRENT_LOW_FLAG(oclf),
        .I_OPEN_LOAD_FLAG(olf), .I_UNDERVOLTAGE_FLAG(uv),
        .I_OVERVOLTAGE_FLAG(ov), .O_READBACK_SELECT_CODE(sel),
        .O_WATCHDOG_ECHO(echo)
    );

    ssrm_master u_mst (
        .i_clk(clk), .i_so(so), .i_so_oe(so_oe),
        .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si)
    );

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // status write, then a non-status frame that carries the view back and flips the watchdog echo
    task automatic view(logic [4:0] c, logic [3:0] n, logic [3:0] s = 4'h0);
        wd_tgl = ~wd_tgl;
        u_mst.xfer({16'h0000, wd_tgl, 7'h00, 3'h0, c}, 16, rx);
        u_mst.xfer({16'h0000, ~wd_tgl, 7'h06, 8'h00}, 16, rx);
        chk("response", rx, {wd_tgl, uv, ov, c, s, n});
        chk("select", {11'h000, sel}, {11'h000, c});
        chk("echo", {15'h0000, echo}, {15'h0000, ~wd_tgl});
    endtask

    task results;
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        results();
    end

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk("pin_rst", {15'h0000, pin_n}, 16'h0001);
        u_mst.xfer(32'h0000_0000, 16, rx);
        chk("first", rx, 16'h0000);
        for (int i = 0; i < 17; i++) begin
            view(tsel[i], tnib[i]);
        end
        @(negedge clk);
        fs_mode = 1'b0;
        view(SEL_WDOG, 4'h2);
        @(negedge clk);
        fs_mode = 1'b1;
        strap = 2'b01;
        view(SEL_FSPIN, 4'h7);
        // 24-bit frame ending in a valid write must be dropped whole
        u_mst.xfer({16'h0000, 1'b1, 7'h00, 3'h0, SEL_ONOFF}, 24, rx);
        chk("short", {10'h000, echo, sel},
            {10'h000, ~wd_tgl, SEL_FSPIN});
        u_mst.xfer({16'hc3a5, 1'b1, 7'h00, 3'h0, SEL_DPIN}, 32, rx);
        chk("chain", rx, 16'hc3a5);
        chk("long", {10'h000, echo, sel}, {10'h000, 1'b1, SEL_DPIN});
        @(negedge clk);
        olf = 4'h4;
        otf = 4'h4;
        view(5'h10, 4'h9, 4'h4);
        chk("pin_on", {15'h0000, pin_n}, 16'h0000);
        @(negedge clk);
        olf = 4'h0;
        otf = 4'h0;
        repeat (2) @(negedge clk);
        chk("pin_off", {15'h0000, pin_n}, 16'h0001);
        ochf = 4'h2;
        repeat (2) @(negedge clk);
        ochf = 4'h0;
        repeat (3) @(negedge clk);
        chk("pin_latch", {15'h0000, pin_n}, 16'h0000);
        onoff = 4'h8;
        repeat (3) @(negedge clk);
        chk("pin_clear", {15'h0000, pin_n}, 16'h0001);
        // latch output 0, then clear it by a falling direct pin
        ochf = 4'h1;
        repeat (2) @(negedge clk);
        ochf = 4'h0;
        repeat (3) @(negedge clk);
        chk("pin_latch0", {15'h0000, pin_n}, 16'h0000);
        dpin = 4'h8;
        repeat (5) @(negedge clk);
        chk("pin_dclear", {15'h0000, pin_n}, 16'h0001);
        uv = 1'b1;
        ov = 1'b1;
        view(SEL_ONOFF, 4'h8);
        chk("pin_supply", {15'h0000, pin_n}, 16'h0000);
        @(negedge clk);
        uv = 1'b0;
        ov = 1'b0;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        chk("rerst", {10'h000, echo, sel}, 16'h0000);
        results();
    end
endmodule
